// ---- sam_ctrl.sv ----
// Synchronous memory pin sequencer: strobes, selects, masks, clock enable, address pins
//
// Function
// - Row strobe low only while a valid row address sits on the pins.
// - Column strobe low only while a valid column address sits on the pins.
// - Write flag high for writes, low for reads.
// - Two block selects, each low only for accesses to its own block.
// - Clock enable gates the memory clock; low allows power-down or self-refresh.
// - With the command option set, clock enable carries an extra command bit.
// - Four byte-lane outputs act as data masks; unselected lanes are masked.
// - Bus clock is driven out as the memory clock.
// - Row phase pins carry same bits; column pins 20-25 carry bits 19-24.
// - Column pins 15-9 carry bits 2-8, pin 16 bit 1 below 32 bits; pin 17 bit 0 for 8-bit ports.
// - Pin 17 carries bit 16 at 32 bits; pin 18 carries bit 17 where allowed.
// - Pin 19 carries column bit 18 for 16-bit ports with nine-plus lines.
// - 8-bit, nine lines: pins 17-9 carry memory address 0-8 both phases.
// - 8-bit, ten lines: pin 19 feeds memory bit 9; pin 18 unused.
// - 8-bit, eleven lines: pin 21 feeds memory bit 10 as well.
// - Multiplexing follows the combined port width seen by the controller.
`timescale 1ns/1ps
module sam_ctrl
    import sam_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire sam_pkg::sam_cfg_s          cfg,
    input  wire logic                       reqValid,
    input  wire sam_pkg::sam_req_s          req,
    output logic                            reqReady,
    output logic                            accessDone,
    output logic                            busClockOut,
    output logic                            row_strobe_n,
    output logic                            column_strobe_n,
    output logic                            mem_write_flag,
    output logic [sam_pkg::BLOCKS-1:0]      block_select_n,
    output logic                            mem_clock_enable,
    output logic [sam_pkg::LANES-1:0]       byte_lane_mask,
    output logic [sam_pkg::ADDR_W-1:0]      addrPins
);
    import sam_pkg::*;

    sam_state_e              state_ff;
    sam_state_e              nxt_state;
    sam_req_s                reqHeld_ff;
    sam_req_s                nxt_reqHeld;
    logic                    rowStrobe_ff;
    logic                    nxt_rowStrobe;
    logic                    colStrobe_ff;
    logic                    nxt_colStrobe;
    logic                    writeFlag_ff;
    logic                    nxt_writeFlag;
    logic [BLOCKS-1:0]       blockSel_ff;
    logic [BLOCKS-1:0]       nxt_blockSel;
    logic                    cke_ff;
    logic                    nxt_cke;
    logic [LANES-1:0]        laneMask_ff;
    logic [LANES-1:0]        nxt_laneMask;
    logic [ADDR_W-1:0]       addrPins_ff;
    logic [ADDR_W-1:0]       muxPins;
    logic [ADDR_W-1:0]       muxAddr;
    logic                    muxColumn;
    logic                    done_ff;
    logic                    nxt_done;

    // Lane enables for a size and byte offset within the port; mask is their inverse
    function automatic logic [LANES-1:0] laneEnable(input logic [1:0] ps, input logic [1:0] sz,
                                                    input logic [1:0] off);
        laneEnable = 4'h0;
        case (ps)
            PORT_8:  laneEnable = 4'h8;
            PORT_16:
            begin
                if (sz == SIZE_BYTE)
                    laneEnable = off[0] ? 4'h4 : 4'h8;
                else
                    laneEnable = 4'hc;
            end
            PORT_32:
            begin
                case (sz)
                    SIZE_BYTE: laneEnable = 4'h8 >> off;
                    SIZE_WORD: laneEnable = off[1] ? 4'h3 : 4'hc;
                    default:   laneEnable = MASK_ALL;
                endcase
            end
            default: laneEnable = MASK_ALL;
        endcase
    endfunction

    // Memory clock leaves the chip as the bus clock itself
    assign busClockOut = clk;

    // Requests are only taken between accesses
    assign reqReady = (state_ff == ST_IDLE);

    // Row address comes from the incoming request, column from the held one
    assign muxAddr   = (state_ff == ST_IDLE) ? req.addr : reqHeld_ff.addr;
    assign muxColumn = (nxt_state == ST_COL);

    // Scheme chosen from the combined port width, not the single part width
    sam_addr_mux uMux (
        .addr        (muxAddr),
        .columnPhase (muxColumn),
        .portSize    (cfg.portSize),
        .colLines    (cfg.colLines),
        .pins        (muxPins)
    );

    always_comb
    begin
        nxt_state   = state_ff;
        nxt_reqHeld = reqHeld_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (reqValid)
                begin
                    nxt_state   = ST_ROW;
                    nxt_reqHeld = req;
                end
            end
            // One idle clock between row and column gives the memory its row delay
            ST_ROW:  nxt_state = ST_GAP;
            ST_GAP:  nxt_state = ST_COL;
            ST_COL:  nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_comb
    begin
        nxt_rowStrobe = (nxt_state == ST_ROW);
        nxt_colStrobe = (nxt_state == ST_COL);
        nxt_done      = (nxt_state == ST_COL);
        nxt_writeFlag = writeFlag_ff;
        nxt_blockSel  = 2'h0;
        nxt_laneMask  = MASK_ALL;
        if (nxt_state == ST_ROW || nxt_state == ST_COL)
            nxt_blockSel = 2'h1 << nxt_reqHeld.block;
        if (nxt_state == ST_COL)
        begin
            nxt_writeFlag = nxt_reqHeld.write;
            nxt_laneMask  = ~laneEnable(cfg.portSize, nxt_reqHeld.size, nxt_reqHeld.addr[1:0]);
        end
        // Externally multiplexed designs reuse clock enable as a command bit
        if (cfg.cmdOption)
            nxt_cke = (nxt_state == ST_IDLE) ? 1'b1 : nxt_reqHeld.cmdBit;
        else
            nxt_cke = ~cfg.powerDown;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff     <= ST_IDLE;
            reqHeld_ff   <= '0;
            rowStrobe_ff <= 1'b0;
            colStrobe_ff <= 1'b0;
            writeFlag_ff <= 1'b0;
            blockSel_ff  <= 2'h0;
            cke_ff       <= 1'b0;
            laneMask_ff  <= MASK_ALL;
            addrPins_ff  <= '0;
            done_ff      <= 1'b0;
        end
        else
        begin
            state_ff     <= nxt_state;
            reqHeld_ff   <= nxt_reqHeld;
            rowStrobe_ff <= nxt_rowStrobe;
            colStrobe_ff <= nxt_colStrobe;
            writeFlag_ff <= nxt_writeFlag;
            blockSel_ff  <= nxt_blockSel;
            cke_ff       <= nxt_cke;
            laneMask_ff  <= nxt_laneMask;
            addrPins_ff  <= muxPins;
            done_ff      <= nxt_done;
        end
    end

    // Block selects are separate pins from the row strobe by construction
    assign row_strobe_n     = ~rowStrobe_ff;
    assign column_strobe_n  = ~colStrobe_ff;
    assign mem_write_flag   = writeFlag_ff;
    assign block_select_n   = ~blockSel_ff;
    assign mem_clock_enable = cke_ff;
    assign byte_lane_mask   = laneMask_ff;
    assign addrPins         = addrPins_ff;
    assign accessDone       = done_ff;

    row_then_col_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(row_strobe_n) |-> ##1 column_strobe_n ##1 !column_strobe_n && row_strobe_n)
        else $error("column strobe not two clocks after row strobe");

    row_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        !row_strobe_n |-> addrPins[PIN_HI:PIN_LO] == reqHeld_ff.addr[PIN_HI:PIN_LO])
        else $error("row address wrong while row strobe low");

    col_low_pins_a: assert property (@(posedge clk) disable iff (!rst_n)
        !column_strobe_n |-> addrPins[9] == reqHeld_ff.addr[8] && addrPins[15] == reqHeld_ff.addr[2])
        else $error("column bits 2 to 8 misplaced");

    col_high_pins_a: assert property (@(posedge clk) disable iff (!rst_n)
        !column_strobe_n && cfg.portSize == PORT_16 && cfg.colLines == 4'ha
        |-> addrPins[20] == reqHeld_ff.addr[19] && addrPins[21] == 1'b0)
        else $error("16-bit ten-line column mapping wrong");

    write_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        !column_strobe_n |-> mem_write_flag == reqHeld_ff.write)
        else $error("write flag does not match access direction");

    block_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!row_strobe_n || !column_strobe_n) |-> !block_select_n[reqHeld_ff.block]
        && block_select_n[~reqHeld_ff.block])
        else $error("wrong block selected");

    idle_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        (row_strobe_n && column_strobe_n) |-> block_select_n == SEL_IDLE_N)
        else $error("block select low outside a command");

    long_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        !column_strobe_n && cfg.portSize == PORT_32 && reqHeld_ff.size == SIZE_LONG
        |-> byte_lane_mask == 4'h0)
        else $error("long access masked a lane");

    cke_power_a: assert property (@(posedge clk) disable iff (!rst_n)
        !cfg.cmdOption && cfg.powerDown |=> !mem_clock_enable || $past(cfg.cmdOption, 1) != 1'b0)
        else $error("clock enable high during power-down");

    cke_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.cmdOption && $stable(cfg.cmdOption) && !column_strobe_n
        |-> mem_clock_enable == reqHeld_ff.cmdBit)
        else $error("clock enable does not carry command bit");

    cover_write_c: cover property (@(posedge clk) disable iff (!rst_n)
        !column_strobe_n && mem_write_flag);
    cover_read_c: cover property (@(posedge clk) disable iff (!rst_n)
        !column_strobe_n && !mem_write_flag && cfg.portSize == PORT_8);
    cover_block1_c: cover property (@(posedge clk) disable iff (!rst_n)
        !row_strobe_n && !block_select_n[1]);
    cover_b2b_c: cover property (@(posedge clk) disable iff (!rst_n)
        accessDone ##2 !row_strobe_n);
endmodule

// ---- sam_pkg.sv ----
// Shared types and constants for the synchronous memory address and strobe block
package sam_pkg;
    localparam int ADDR_W      = 32;
    localparam int PIN_LO      = 9;
    localparam int PIN_HI      = 31;
    localparam int LANES       = 4;
    localparam int BLOCKS      = 2;
    localparam int GEN_PIN_TOP = 25;

    // Port size as the controller sees it
    localparam logic [1:0] PORT_8  = 2'h0;
    localparam logic [1:0] PORT_16 = 2'h1;
    localparam logic [1:0] PORT_32 = 2'h2;

    // Access size
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    // Column line counts and per-port first extra pin and base count
    localparam logic [3:0] COL_MIN    = 4'h8;
    localparam logic [3:0] COL_MAX    = 4'hd;
    localparam int         FIRST_X8   = 19;
    localparam int         FIRST_X16  = 18;
    localparam int         FIRST_X32  = 17;
    localparam int         BASE_8     = 9;
    localparam int         BASE_16    = 8;
    localparam int         BASE_32    = 7;
    localparam int         PIN_B0_8   = 17;
    localparam int         PIN_B1     = 16;
    localparam int         PIN_C17    = 18;
    localparam int         PIN_C18    = 19;
    localparam int         COL_SUM    = 17;

    localparam logic [1:0]  SEL_IDLE_N = 2'h3;
    localparam logic [3:0]  MASK_ALL   = 4'hf;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ROW  = 4'h2,
        ST_GAP  = 4'h4,
        ST_COL  = 4'h8
    } sam_state_e;

    typedef struct packed {
        logic              write;
        logic              block;
        logic [1:0]        size;
        logic              cmdBit;
        logic [ADDR_W-1:0] addr;
    } sam_req_s;

    typedef struct packed {
        logic [1:0] portSize;
        logic [3:0] colLines;
        logic       cmdOption;
        logic       powerDown;
    } sam_cfg_s;
endpackage

// ---- sam_addr_mux.sv ----
// Row and column multiplexing of byte-address bits onto the shared address pins
`timescale 1ns/1ps
module sam_addr_mux
    import sam_pkg::*;
(
    input  wire logic [sam_pkg::ADDR_W-1:0] addr,
    input  wire logic                       columnPhase,
    input  wire logic [1:0]                 portSize,
    input  wire logic [3:0]                 colLines,
    output logic      [sam_pkg::ADDR_W-1:0] pins
);
    // Whether pin p carries a column bit for this port size and line count
    function automatic logic colUsed(input int p, input logic [1:0] ps, input logic [3:0] cl);
        int first;
        int base;
        int k;
        first = (ps == PORT_8) ? FIRST_X8 : ((ps == PORT_16) ? FIRST_X16 : FIRST_X32);
        base  = (ps == PORT_8) ? BASE_8 : ((ps == PORT_16) ? BASE_16 : BASE_32);
        k     = p - first;
        colUsed = 1'b0;
        if (p < PIN_B1)
            colUsed = 1'b1;
        else if (p == PIN_B1)
            colUsed = (ps != PORT_32);
        else if (p == PIN_B0_8 && ps == PORT_8)
            colUsed = 1'b1;
        else if (p == PIN_C17 && ps == PORT_32 && cl == COL_MIN)
            colUsed = 1'b1;
        else if (p == PIN_C18 && ps == PORT_16 && cl > COL_MIN)
            colUsed = 1'b1;
        else if (k >= 0 && k[0] == 1'b0 && (k / 2) < (int'(cl) - base))
            colUsed = 1'b1;
    endfunction

    genvar g;
    generate
        for (g = 0; g < ADDR_W; g++)
        begin : gPin
            if (g < PIN_LO)
            begin : gLow
                assign pins[g] = 1'b0;
            end
            else if (g < PIN_B0_8)
            begin : gLowCol
                // Pins 15 down to 9 carry bits 2 to 8; pin 16 carries bit 1 below 32 bits
                assign pins[g] = columnPhase ? (addr[COL_SUM - g] & colUsed(g, portSize, colLines))
                                             : addr[g];
            end
            else if (g == PIN_B0_8)
            begin : gPin17
                assign pins[g] = columnPhase ? ((portSize == PORT_8) ? addr[0] : (addr[g-1]
                                 & colUsed(g, portSize, colLines))) : addr[g];
            end
            else
            begin : gHigh
                // Upper pins carry the next lower bit in the column phase
                assign pins[g] = columnPhase ? (addr[g-1] & colUsed(g, portSize, colLines))
                                             : addr[g];
            end
        end
    endgenerate
endmodule

// ---- sam_mem_model.sv ----
// Passive memory-side model that latches the row and column phases
`timescale 1ns/1ps
module sam_mem_model
    import sam_pkg::*;
(
    input  wire logic                       memClk,
    input  wire logic                       row_strobe_n,
    input  wire logic                       column_strobe_n,
    input  wire logic [sam_pkg::BLOCKS-1:0] block_select_n,
    input  wire logic [sam_pkg::ADDR_W-1:0] addrPins,
    input  wire logic                       mem_write_flag,
    input  wire logic [sam_pkg::LANES-1:0]  byte_lane_mask,
    output logic      [sam_pkg::ADDR_W-1:0] rowLatched,
    output logic      [sam_pkg::ADDR_W-1:0] colLatched,
    output logic                            writeLatched,
    output logic      [sam_pkg::LANES-1:0]  maskLatched
);
    // Only the mapped pins reach the memory; pins below 9 stay unwired
    always_ff @(posedge memClk)
    begin
        // A row opens on the row strobe only while a block select is also low
        if (!row_strobe_n && (block_select_n != SEL_IDLE_N))
            rowLatched <= addrPins & 32'hffff_fe00;
        if (!column_strobe_n)
        begin
            colLatched   <= addrPins & 32'hffff_fe00;
            writeLatched <= mem_write_flag;
            maskLatched  <= byte_lane_mask;
        end
    end
endmodule

// ---- sam_ctrl_bench.sv ----
// Self-checking bench for the memory strobe and address sequencer
`timescale 1ns/1ps
module sam_ctrl_bench;
    import sam_pkg::*;
    logic                clk;
    logic                rst_n;
    sam_cfg_s            cfg;
    logic                reqValid;
    sam_req_s            req;
    logic                reqReady;
    logic                accessDone;
    logic                busClockOut;
    logic                row_strobe_n;
    logic                column_strobe_n;
    logic                mem_write_flag;
    logic [BLOCKS-1:0]   block_select_n;
    logic                mem_clock_enable;
    logic [LANES-1:0]    byte_lane_mask;
    logic [ADDR_W-1:0]   addrPins;
    logic [ADDR_W-1:0]   rowLatched;
    logic [ADDR_W-1:0]   colLatched;
    logic                writeLatched;
    logic [LANES-1:0]    maskLatched;
    int                  err_total;
    int                  samples_checked;

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    sam_ctrl dut (.clk(clk), .rst_n(rst_n), .cfg(cfg), .reqValid(reqValid), .req(req), .reqReady(reqReady),
        .accessDone(accessDone), .busClockOut(busClockOut), .row_strobe_n(row_strobe_n),
        .column_strobe_n(column_strobe_n), .mem_write_flag(mem_write_flag), .block_select_n(block_select_n),
        .mem_clock_enable(mem_clock_enable), .byte_lane_mask(byte_lane_mask), .addrPins(addrPins));

    sam_mem_model mem (.memClk(busClockOut), .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
        .block_select_n(block_select_n), .addrPins(addrPins), .mem_write_flag(mem_write_flag),
        .byte_lane_mask(byte_lane_mask), .rowLatched(rowLatched), .colLatched(colLatched),
        .writeLatched(writeLatched), .maskLatched(maskLatched));

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    task automatic end_of_test;
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [31:0] colExp(input logic [31:0] a, input logic [1:0] ps, input logic [3:0] cl);
        logic [31:0] e;
        int          n;
        e = '0;
        n = int'(cl);
        for (int p = 9; p <= 15; p++)
            e[p] = a[17-p];
        if (ps != PORT_32)
            e[16] = a[1];
        if (ps == PORT_8)
        begin
            e[17] = a[0];
            for (int k = 0; k < n - 9; k++)
                e[19+2*k] = a[18+2*k];
        end
        else if (ps == PORT_16)
        begin
            for (int k = 0; k < n - 8; k++)
                e[18+2*k] = a[17+2*k];
            if (n > 8)
                e[19] = a[18];
        end
        else
        begin
            for (int k = 0; k < n - 7; k++)
                e[17+2*k] = a[16+2*k];
            if (n == 8)
                e[18] = a[17];
        end
        return e;
    endfunction

    // 1 = masked; lane 3 carries the most significant byte
    function automatic logic [3:0] maskExp(input logic [1:0] ps, input logic [1:0] sz, input logic [1:0] lo);
        if (ps == PORT_8)
            return 4'h7;
        if (ps == PORT_16)
            return (sz == SIZE_BYTE) ? (lo[0] ? 4'hb : 4'h7) : 4'h3;
        if (sz == SIZE_BYTE)
            return ~(4'h8 >> lo);
        if (sz == SIZE_WORD)
            return lo[1] ? 4'hc : 4'h3;
        return 4'h0;
    endfunction

    // Checks every cycle so a reset in mid-access must suppress the column phase
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (12)
        begin
            @(posedge clk);
            #1;
            chk("resetIdle", {1'b1, 1'b1, 1'b0, 2'h3, 1'b0, 4'hf, 1'b1, 1'b0, 32'h0}, {row_strobe_n, column_strobe_n,
                mem_write_flag, block_select_n, mem_clock_enable, byte_lane_mask, reqReady, accessDone, addrPins});
        end
        @(posedge clk) rst_n <= 1'b1;
    endtask

    task automatic setCfg(input logic [1:0] ps, input logic [3:0] cl, input logic opt, input logic pd);
        @(posedge clk) cfg <= '{portSize: ps, colLines: cl, cmdOption: opt, powerDown: pd};
    endtask

    task automatic access(input logic w, input logic b, input logic [1:0] sz, input logic cb, input logic [31:0] a);
        logic [1:0]  sel;
        logic [31:0] col;
        logic [3:0]  msk;
        sel = b ? 2'h1 : 2'h2;
        // A configuration written at the previous edge only lands after it
        @(posedge clk);
        col = colExp(a, cfg.portSize, cfg.colLines);
        msk = maskExp(cfg.portSize, sz, a[1:0]);
        reqValid <= 1'b1;
        req <= '{write: w, block: b, size: sz, cmdBit: cb, addr: a};
        @(posedge clk);
        reqValid <= 1'b0;
        #1;
        chk("rowPhase", {1'b0, 1'b1, 1'b0, sel, 1'b1}, {row_strobe_n, column_strobe_n, reqReady, block_select_n,
            busClockOut});
        chk("rowPins", {a[31:9], 9'h0}, addrPins);
        chk("ckeRow", cfg.cmdOption ? cb : !cfg.powerDown, mem_clock_enable);
        @(posedge clk);
        #1;
        chk("gap", {1'b1, 1'b1, 2'h3, 1'b0}, {row_strobe_n, column_strobe_n, block_select_n, reqReady});
        chk("rowLatched", {a[31:9], 9'h0}, rowLatched);
        @(posedge clk);
        #1;
        chk("colPhase", {1'b1, 1'b0, 1'b1, w, sel}, {row_strobe_n, column_strobe_n, accessDone, mem_write_flag,
            block_select_n});
        chk("colPins", col, addrPins);
        chk("laneMask", msk, byte_lane_mask);
        chk("ckeCol", cfg.cmdOption ? cb : !cfg.powerDown, mem_clock_enable);
        @(posedge clk);
        #1;
        chk("colLatched", {col, w, msk}, {colLatched, writeLatched, maskLatched});
        chk("backIdle", {1'b1, 1'b0, 4'hf, cfg.cmdOption | ~cfg.powerDown}, {reqReady, accessDone, byte_lane_mask,
            mem_clock_enable});
    endtask

    task automatic test_mapping;
        for (int p = 0; p < 3; p++)
            for (int c = 8; c <= 13; c++)
                if (!((p == 0 && c < 9) || (p == 1 && c > 12) || (p == 2 && c > 11)))
                begin
                    setCfg(p[1:0], c[3:0], 1'b0, 1'b0);
                    access(c[0], c[0], SIZE_LONG, 1'b0, c[0] ? 32'h5a3c_a5c0 : 32'ha5c3_5a3c);
                end
    endtask

    task automatic test_lanes;
        for (int p = 0; p < 3; p++)
        begin
            setCfg(p[1:0], 4'h9, 1'b0, 1'b0);
            for (int s = 0; s < 3; s++)
                for (int lo = 0; lo < 4; lo++)
                    if (!((s == 2 && lo != 0) || (s == 1 && lo[0])))
                        access(1'b1, lo[0], s[1:0], 1'b0, 32'h1234_5670 | lo);
        end
    endtask

    // Clock enable low while powered down, then as a command bit
    task automatic test_cke;
        setCfg(PORT_32, 4'h8, 1'b0, 1'b1);
        access(1'b0, 1'b0, SIZE_LONG, 1'b1, 32'h0000_0000);
        for (int b = 0; b < 2; b++)
        begin
            setCfg(PORT_32, 4'h8, 1'b1, b[0]);
            access(1'b1, b[0], SIZE_LONG, b[0], 32'hffff_fffc);
        end
    endtask

    // Request held high: refused until the column cycle ends, then reset in mid-access
    task automatic test_b2b;
        setCfg(PORT_16, 4'h9, 1'b0, 1'b0);
        @(posedge clk);
        reqValid <= 1'b1;
        req <= '{write: 1'b1, block: 1'b1, size: SIZE_WORD, cmdBit: 1'b0, addr: 32'h0001_2340};
        @(posedge clk);
        for (int i = 1; i <= 4; i++)
        begin
            @(posedge clk);
            if (i == 4)
                reqValid <= 1'b0;
            #1;
            chk("heldRequest", (i == 4) ? 1'b0 : 1'b1, row_strobe_n);
        end
        @(posedge clk);
        do_reset;
        @(posedge clk);
        #1;
        chk("afterReset", {1'b1, 1'b1, 1'b1, 1'b1}, {row_strobe_n, column_strobe_n, reqReady,
            mem_clock_enable});
        // A full access must still work once the mid-run reset is released
        access(1'b0, 1'b0, SIZE_WORD, 1'b0, 32'h0000_1230);
    endtask

    initial
    begin
        err_total = 0;
        samples_checked = 0;
        reqValid = 1'b0;
        req = '0;
        cfg = '{portSize: PORT_32, colLines: 4'h8, cmdOption: 1'b0, powerDown: 1'b0};
        do_reset;
        test_mapping;
        test_lanes;
        test_cke;
        test_b2b;
        end_of_test;
    end

    // Whole run needs well under 600 cycles
    initial
    begin
        repeat (3000) @(posedge clk);
        err_total++;
        end_of_test;
    end
endmodule
